// *** design/odac_serial_load.v ***
// octal dac serial frame receiver, load strobe and clear logic
//
// Overview of operation
// (RULE1) frame select low enables shifting; next 32 falling serial clocks are captured
// (RULE2) frame select rising before the 32nd falling edge discards the partial frame
// (RULE3) 32-bit shift register samples data on each falling serial clock edge
// (RULE4) load strobe low copies all channels holding new data into dac registers together
// (RULE5) load strobe held permanently low still works, updating after each write
// (RULE6) clear acts on falling edge of clear input, independent of serial clock
// (RULE7) while clear input is low, load strobe is ignored entirely
// (RULE8) clear writes input and dac registers with selected zero, mid or full code
// (RULE9) after reset the clear code selects zero scale
// (RULE10) reference pin is input by default, output only when internal reference chosen
// (RULE11) frame: cmd[31:28], channel[27:24], data[23:8]; 12-bit channels use [23:12]
`timescale 1ns/1ps
`default_nettype none
`include "odac_regs.vh"

module odac_serial_load (
  // clock and reset
  input  wire         clk_sys,
  input  wire         nrst,
  // serial link
  input  wire         frame_n,
  input  wire         sclk,
  input  wire         din,
  // control pins
  input  wire         load_strobe_n,
  input  wire         async_clear_n,
  // dac side
  output reg  [127:0] dac_code_r,
  output reg          ref_out_en_r
);

  // ----------------------------------------------------------------
  // clear value per channel; channels 4..7 are 12 bit
  // ----------------------------------------------------------------
  function [15:0] clr_val;
    input [2:0] ch;
    input [1:0] code;
    begin
      case (code)
        `ODAC_CLR_MID:  clr_val = ch[2] ? `ODAC_MID12 : `ODAC_MID16;
        `ODAC_CLR_FULL: clr_val = ch[2] ? `ODAC_FULL12 : `ODAC_FULL16;
        default:        clr_val = `ODAC_CODE_RST;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // written value per channel; 12-bit channels keep the upper bits
  // ----------------------------------------------------------------
  function [15:0] wr_val;
    input [2:0]  ch;
    input [15:0] d;
    begin
      wr_val = ch[2] ? {4'h0, d[15:4]} : d;
    end
  endfunction

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  reg         sclk_q_r;
  reg         clr_q_r;
  reg  [31:0] shift_r;
  reg  [5:0]  cnt_r;
  reg  [1:0]  clr_code_r;
  reg  [15:0] in_r [0:7];
  reg  [7:0]  pend_r;

  // ----------------------------------------------------------------
  // edges and frame decode
  // ----------------------------------------------------------------
  // fields are read from the word including the bit taken on this edge
  wire        sclk_fall  = sclk_q_r & ~sclk;
  wire        clr_fall   = clr_q_r & ~async_clear_n;  // RULE6
  wire        bit_take   = sclk_fall & ~frame_n & (cnt_r != `ODAC_FRAME_BITS);
  wire [31:0] shift_nxt  = {shift_r[30:0], din};
  wire        last_edge  = bit_take & (cnt_r == `ODAC_CNT_LAST);
  wire [3:0]  cmd        = shift_nxt[`ODAC_CMD_MSB:`ODAC_CMD_LSB];
  wire [3:0]  addr       = shift_nxt[`ODAC_ADDR_MSB:`ODAC_ADDR_LSB];
  wire [15:0] data16     = shift_nxt[`ODAC_DATA_MSB:`ODAC_DATA_LSB];
  wire        cmd_wr     = (cmd == `ODAC_CMD_WR) | (cmd == `ODAC_CMD_WR_UPD) |
                           (cmd == `ODAC_CMD_WR_UPDALL);
  wire        cmd_upd    = (cmd == `ODAC_CMD_UPD) | (cmd == `ODAC_CMD_WR_UPD);
  wire        cmd_updall = (cmd == `ODAC_CMD_WR_UPDALL);
  wire        strobe_ok  = ~load_strobe_n & async_clear_n;  // RULE7

  // ----------------------------------------------------------------
  // per channel select
  // ----------------------------------------------------------------
  reg  [7:0]  hit_v;
  reg  [7:0]  wr_v;
  reg  [7:0]  sw_upd_v;
  reg  [7:0]  load_strobe_n_v;
  reg  [7:0]  upd_v;
  integer     k;

  always @* begin
    hit_v    = 8'h00;
    wr_v     = 8'h00;
    sw_upd_v = 8'h00;
    load_strobe_n_v   = 8'h00;
    upd_v    = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      hit_v[k]    = (addr == k[3:0]) | (addr == `ODAC_ADDR_ALL);
      wr_v[k]     = last_edge & hit_v[k] & cmd_wr;  // RULE11
      sw_upd_v[k] = last_edge & ((cmd_upd & hit_v[k]) | cmd_updall);
      // level sensitive so a strobe tied low keeps updating
      load_strobe_n_v[k]   = strobe_ok & (pend_r[k] | wr_v[k]);  // RULE4 RULE5
      upd_v[k]    = sw_upd_v[k] | load_strobe_n_v[k];
    end
  end

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      sclk_q_r <= `ODAC_EDGE_RST;
      clr_q_r  <= `ODAC_EDGE_RST;
    end else begin
      sclk_q_r <= sclk;
      clr_q_r  <= async_clear_n;
    end
  end

  // ----------------------------------------------------------------
  // shift register and bit count
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      shift_r <= `ODAC_SHIFT_RST;
      cnt_r   <= `ODAC_CNT_RST;
    end else if (frame_n) begin
      // frame select high aborts any partial frame
      cnt_r <= `ODAC_CNT_RST;  // RULE2
    end else if (bit_take) begin
      shift_r <= shift_nxt;  // RULE1 RULE3
      cnt_r   <= cnt_r + `ODAC_CNT_STEP;
    end
  end

  // ----------------------------------------------------------------
  // configuration commands
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      clr_code_r   <= `ODAC_CLRCODE_RST;  // RULE9
      ref_out_en_r <= `ODAC_REFOUT_RST;   // RULE10
    end else if (last_edge) begin
      if (cmd == `ODAC_CMD_CLRCODE) begin
        clr_code_r <= shift_nxt[`ODAC_CLRSEL_MSB:`ODAC_CLRSEL_LSB];  // RULE8
      end
      if (cmd == `ODAC_CMD_REFSEL) begin
        ref_out_en_r <= shift_nxt[`ODAC_REFSEL_BIT];  // RULE10
      end
    end
  end

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  integer     ch_in;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      for (ch_in = 0; ch_in < 8; ch_in = ch_in + 1) begin
        in_r[ch_in] <= `ODAC_CODE_RST;
      end
    end else begin
      for (ch_in = 0; ch_in < 8; ch_in = ch_in + 1) begin
        if (clr_fall) begin
          in_r[ch_in] <= clr_val(ch_in[2:0], clr_code_r);  // RULE6 RULE8
        end else if (wr_v[ch_in]) begin
          in_r[ch_in] <= wr_val(ch_in[2:0], data16);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // dac registers
  // ----------------------------------------------------------------
  integer     ch_dac;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      dac_code_r <= `ODAC_DAC_RST;
    end else begin
      for (ch_dac = 0; ch_dac < 8; ch_dac = ch_dac + 1) begin
        if (clr_fall) begin
          dac_code_r[ch_dac*16+:16] <= clr_val(ch_dac[2:0], clr_code_r);  // RULE8
        end else if (upd_v[ch_dac]) begin
          // every selected channel moves on the same clock edge
          dac_code_r[ch_dac*16+:16] <= wr_v[ch_dac] ? wr_val(ch_dac[2:0], data16) :
                                       in_r[ch_dac];  // RULE4
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pending new data per channel
  // ----------------------------------------------------------------
  integer     ch_pend;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      pend_r <= `ODAC_PEND_RST;
    end else begin
      for (ch_pend = 0; ch_pend < 8; ch_pend = ch_pend + 1) begin
        // a transfer consumes the data; clear wins over a write
        if (clr_fall | upd_v[ch_pend]) begin
          pend_r[ch_pend] <= 1'b0;
        end else if (wr_v[ch_pend]) begin
          pend_r[ch_pend] <= 1'b1;  // RULE4
        end
      end
    end
  end

endmodule // odac_serial_load

`default_nettype wire

// *** design/odac_regs.vh ***
// constants of the octal dac serial load front end
`ifndef ODAC_REGS_VH
`define ODAC_REGS_VH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define ODAC_FRAME_BITS    6'h20
`define ODAC_CNT_LAST      6'h1f
`define ODAC_CNT_STEP      6'h01
`define ODAC_CMD_MSB       31
`define ODAC_CMD_LSB       28
`define ODAC_ADDR_MSB      27
`define ODAC_ADDR_LSB      24
`define ODAC_DATA_MSB      23
`define ODAC_DATA_LSB      8
`define ODAC_ADDR_ALL      4'hf
`define ODAC_CLRSEL_MSB    9
`define ODAC_CLRSEL_LSB    8
`define ODAC_REFSEL_BIT    8

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define ODAC_CMD_WR        4'h0
`define ODAC_CMD_UPD       4'h1
`define ODAC_CMD_WR_UPDALL 4'h2
`define ODAC_CMD_WR_UPD    4'h3
`define ODAC_CMD_CLRCODE   4'h5
`define ODAC_CMD_REFSEL    4'h8

// ----------------------------------------------------------------
// clear codes and reset values
// ----------------------------------------------------------------
`define ODAC_CLR_ZERO      2'h0
`define ODAC_CLR_MID       2'h1
`define ODAC_CLR_FULL      2'h2
`define ODAC_MID16         16'h8000
`define ODAC_MID12         16'h0800
`define ODAC_FULL16        16'hffff
`define ODAC_FULL12        16'h0fff
`define ODAC_CODE_RST      16'h0000
`define ODAC_CLRCODE_RST   2'h0
`define ODAC_REFOUT_RST    1'b0
`define ODAC_SHIFT_RST     32'h0000_0000
`define ODAC_CNT_RST       6'h00
`define ODAC_EDGE_RST      1'b1
`define ODAC_PEND_RST      8'h00
`define ODAC_DAC_RST       128'h0

`endif

// *** verification/odac_asserts.sv ***
// port assertions for the octal dac serial load front end
`timescale 1ns/1ps
`default_nettype none
module odac_asserts (
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         nrst,
  // serial link
  input wire logic         frame_n,
  input wire logic         sclk,
  input wire logic         din,
  // control pins
  input wire logic         load_strobe_n,
  input wire logic         async_clear_n,
  // dac side
  input wire logic [127:0] dac_code_r,
  input wire logic         ref_out_en_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence clr_fall;
    async_clear_n ##1 !async_clear_n;
  endsequence
  a_reset_clears: assert property (disable iff (1'b0) !nrst |=> !dac_code_r && !ref_out_en_r)
    else $error("reset value");
  a_clear_value: assert property (clr_fall |=> dac_code_r[15:0] == dac_code_r[63:48]
    && dac_code_r[79:64] == {4'h0, dac_code_r[15:4]}) else $error("clear value");
  a_clear_blocks: assert property (!async_clear_n && $past(!async_clear_n && nrst) && frame_n
    |=> $stable(dac_code_r)) else $error("strobe during clear");
  a_idle_hold: assert property (frame_n && load_strobe_n && async_clear_n && $past(nrst)
    |=> $stable(dac_code_r)) else $error("idle change");
  a_held_once: assert property (!load_strobe_n && frame_n && async_clear_n
    && $past(!load_strobe_n && frame_n && async_clear_n && nrst) |=> $stable(dac_code_r))
    else $error("repeat load");
  a_change_cause: assert property ($changed(dac_code_r)
    |-> $past(!frame_n || !load_strobe_n || !async_clear_n || !nrst)) else $error("no cause");
  a_ref_frame: assert property ($changed(ref_out_en_r) |-> $past(!frame_n || !nrst))
    else $error("ref change");
  a_narrow_ch: assert property (!{dac_code_r[79:76], dac_code_r[95:92],
    dac_code_r[111:108], dac_code_r[127:124]}) else $error("wide code");
endmodule // odac_asserts
bind odac_serial_load odac_asserts i_odac_asserts (.clk_sys, .nrst, .frame_n, .sclk, .din,
  .load_strobe_n, .async_clear_n, .dac_code_r, .ref_out_en_r);
`default_nettype wire

// *** verification/odac_host_model.sv ***
// serial host model that sends frames msb first
`timescale 1ns/1ps
`default_nettype none
module odac_host_model (
  input  wire logic clk_sys,
  output var  logic frame_n = 1'b1,
  output var  logic sclk = 1'b1,
  output var  logic din = 1'b0
);
  // n below 32 closes the frame early
  task automatic send(input logic [31:0] w, input int n);
    frame_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      din = w[31-i];
      repeat (2) @(negedge clk_sys);
      sclk = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
    frame_n = 1'b1;
    sclk = 1'b1;
    din = ~din;
    repeat (2) @(negedge clk_sys);
  endtask
endmodule // odac_host_model
`default_nettype wire

// *** verification/odac_serial_load_tb.sv ***
// self-checking bench of the octal dac serial load front end
`timescale 1ns/1ps
`default_nettype none
`include "odac_regs.vh"
module odac_serial_load_tb;
  logic             clk_sys = 1'b0, nrst = 1'b0, load_strobe_n = 1'b1, async_clear_n = 1'b1;
  wire logic        frame_n, sclk, din, ref_out_en_r;
  wire logic [127:0] dac_code_r;
  int               mismatches = 0, comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  odac_host_model i_odac_host_model (.clk_sys, .frame_n, .sclk, .din);
  odac_serial_load i_odac_serial_load (.clk_sys, .nrst, .frame_n, .sclk, .din, .load_strobe_n,
    .async_clear_n, .dac_code_r, .ref_out_en_r);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %h %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [3:0] c, a, input logic [15:0] d, input int n = 32);
    i_odac_host_model.send({c, a, d, 8'h00}, n);
  endtask
  task automatic strobe;
    load_strobe_n = 1'b0;
    @(negedge clk_sys);
    load_strobe_n = 1'b1;
    @(negedge clk_sys);
  endtask
  task automatic t_load;
    put(`ODAC_CMD_WR, 4'h1, 16'h1234);
    put(`ODAC_CMD_WR, 4'h5, 16'habcd);
    chk(dac_code_r[31:16], 16'h0000);
    strobe;
    chk(dac_code_r[31:16], 16'h1234);
    chk(dac_code_r[95:80], 16'h0abc);
  endtask
  task automatic t_abort;
    put(`ODAC_CMD_WR_UPD, 4'h2, 16'h5555, 31);
    chk(dac_code_r[47:32], 16'h0000);
    put(`ODAC_CMD_WR_UPD, 4'h2, 16'h5555);
    chk(dac_code_r[47:32], 16'h5555);
  endtask
  task automatic t_ref;
    put(`ODAC_CMD_REFSEL, 4'h0, 16'h0001);
    chk({15'h0, ref_out_en_r}, 16'h0001);
    put(`ODAC_CMD_REFSEL, 4'h0, 16'h0000);
    chk({15'h0, ref_out_en_r}, 16'h0000);
  endtask
  task automatic t_update;
    put(`ODAC_CMD_WR, 4'h0, 16'h4321);
    chk(dac_code_r[15:0], `ODAC_FULL16);
    put(`ODAC_CMD_UPD, 4'h0, 16'h0000);
    chk(dac_code_r[15:0], 16'h4321);
    put(`ODAC_CMD_WR_UPDALL, `ODAC_ADDR_ALL, 16'h9abc);
    chk(dac_code_r[47:32], 16'h9abc);
    chk(dac_code_r[127:112], 16'h09ab);
  endtask
  task automatic t_clear(input logic [1:0] c, input logic [15:0] e);
    async_clear_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(dac_code_r[15:0], e);
    chk(dac_code_r[111:96], e >> 4);
    put(`ODAC_CMD_WR, 4'h1, 16'h1111);
    strobe;
    chk(dac_code_r[31:16], e);
    async_clear_n = 1'b1;
    put(`ODAC_CMD_CLRCODE, 4'h0, {14'h0, c});
  endtask
  task automatic t_held;
    load_strobe_n = 1'b0;
    put(`ODAC_CMD_WR, 4'h3, 16'h7777);
    chk(dac_code_r[63:48], 16'h7777);
    put(`ODAC_CMD_WR, 4'h3, 16'h0123);
    chk(dac_code_r[63:48], 16'h0123);
    load_strobe_n = 1'b1;
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    chk({15'h0, ref_out_en_r}, 16'h0000);
    t_load;
    t_abort;
    t_ref;
    t_clear(`ODAC_CLR_MID, 16'h0000);
    t_clear(`ODAC_CLR_FULL, `ODAC_MID16);
    t_clear(`ODAC_CLR_ZERO, `ODAC_FULL16);
    t_update;
    t_held;
    complete_run;
  end
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
endmodule // odac_serial_load_tb
`default_nettype wire
